// file: logic/pefd_divider.sv
// Programmable divider of a rising-edge stream with phase and high time
`timescale 1ns/100ps
// Contract
// R01 - Count only rising edges of the input
// R02 - Output period equals ratio in edges
// R03 - High time equals pulse length edges
// R04 - Counter starts from start count
// R05 - High at count one plus ratio multiples
// R06 - Start zero: high on first edge
// R07 - Start five: high on sixth edge
// R08 - Integrator keeps pulse length below ratio; the code does not limit pulse_len by ratio, it only raises it to at least one
module pefd_divider #(
  parameter int CNT_W = pefd_pkg::CNT_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic freq_in,
  input wire logic [CNT_W-1:0] ratio,
  input wire logic [CNT_W-1:0] pulse_len,
  input wire logic [CNT_W-1:0] start_count,
  output logic freq_out
);
  pefd_pkg::pefd_state_t state;
  pefd_pkg::pefd_state_t next_state;
  logic [CNT_W-1:0] delay_left;
  logic [CNT_W-1:0] next_delay_left;
  logic [CNT_W-1:0] phase;
  logic [CNT_W-1:0] next_phase;
  logic [CNT_W-1:0] ratio_eff;
  logic [CNT_W-1:0] pulse_eff;
  logic next_freq_out;
  logic rise;

  // Ratio and pulse length below the minimum are raised to one rather than stalling
  function automatic logic [CNT_W-1:0] at_least_one(
    input logic [CNT_W-1:0] v
  );
    at_least_one = (v < CNT_W'(pefd_pkg::SETTING_MIN)) ?
      CNT_W'(pefd_pkg::SETTING_MIN) : v;
  endfunction

  assign ratio_eff = at_least_one(ratio);
  assign pulse_eff = at_least_one(pulse_len);

  pefd_rise_detect u_rise (
    .clock(clock),
    .rst_n(rst_n),
    .level(freq_in),
    .rise(rise)
  );

  always_comb begin
    next_state = state;
    next_delay_left = delay_left;
    next_phase = phase;
    next_freq_out = freq_out;
    case (state)
      pefd_pkg::PEFD_IDLE: begin
        next_state = pefd_pkg::PEFD_DELAY;
      end
      pefd_pkg::PEFD_DELAY: begin
        if (rise) begin // R01
          if (delay_left == CNT_W'(pefd_pkg::COUNT_ZERO)) begin
            // Counter reaches one on this edge: first high phase
            next_state = pefd_pkg::PEFD_RUN; // R06
            next_freq_out = 1'b1; // R05
            next_phase = (ratio_eff == CNT_W'(pefd_pkg::COUNT_ONE)) ?
              CNT_W'(pefd_pkg::COUNT_ZERO) : CNT_W'(pefd_pkg::COUNT_ONE);
          end else begin
            next_delay_left = delay_left - CNT_W'(pefd_pkg::COUNT_ONE); // R07
          end
        end
      end
      pefd_pkg::PEFD_RUN: begin
        if (rise) begin // R01
          // Phase zero is count one plus a multiple of the ratio
          next_freq_out = (phase < pulse_eff); // R03 R05
          if (phase >= ratio_eff - CNT_W'(pefd_pkg::COUNT_ONE)) begin
            next_phase = CNT_W'(pefd_pkg::COUNT_ZERO); // R02
          end else begin
            next_phase = phase + CNT_W'(pefd_pkg::COUNT_ONE);
          end
        end
      end
      default: begin
        next_state = pefd_pkg::PEFD_IDLE;
        next_freq_out = 1'b0;
      end
    endcase
  end

  // Reset is synchronous, so the start count is captured while it is held
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= pefd_pkg::PEFD_IDLE;
      delay_left <= start_count; // R04
      phase <= CNT_W'(pefd_pkg::COUNT_ZERO);
      freq_out <= 1'b0;
    end else begin
      state <= next_state;
      delay_left <= next_delay_left;
      phase <= next_phase;
      freq_out <= next_freq_out;
    end
  end
endmodule

// file: logic/pefd_pkg.sv
// Package with widths, defaults and state codes for the edge divider
package pefd_pkg;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] RATIO_RESET = 16'h0002;
  localparam logic [CNT_W-1:0] PULSE_RESET = 16'h0001;
  localparam logic [CNT_W-1:0] START_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] SETTING_MIN = 16'h0001;
  localparam logic [CNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;

  typedef enum logic [1:0] {
    PEFD_IDLE = 2'b00,
    PEFD_DELAY = 2'b01,
    PEFD_RUN = 2'b10
  } pefd_state_t;
endpackage

// file: logic/pefd_rise_detect.sv
// Rising edge detector for a synchronous input level
`timescale 1ns/100ps
module pefd_rise_detect (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic level,
  output logic rise
);
  logic last;
  logic next_last;

  always_comb begin
    next_last = level;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      last <= 1'b0;
    end else begin
      last <= next_last;
    end
  end

  // A level already high at reset release raises rise on the clock the divider spends idle, so it is not counted
  assign rise = level & ~last;
endmodule

// file: sim/pefd_chk.sv
// Port checker
`timescale 1ns/100ps
module pefd_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic freq_in,
  input wire logic freq_out,
  input wire logic [15:0] ratio,
  input wire logic [15:0] pulse_len,
  input wire logic [15:0] start_count
);
  logic [15:0] n;
  always_ff @(posedge clock) n <= rst_n ? n + {15'h0, $rose(freq_in)} : 16'h0;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_hold_out: assert property (
    !$rose(freq_in) |=> $stable(freq_out)) else $error("moved");
  chk_out_phase: assert property (
    $rose(freq_in) |=> freq_out == (n > start_count &&
    (n - start_count - 16'h1) % ratio < pulse_len)) else $error("phase");
  chk_fall_quiet: assert property (
    $fell(freq_in) |=> $stable(freq_out)) else $error("fall moved");
  chk_first_high: assert property (
    $rose(freq_in) && start_count == 16'h0 && n == 16'h0 |=> freq_out)
    else $error("first rise low");
  chk_sixth_rise: assert property (
    $rose(freq_in) && start_count == 16'h5 && n < 16'h6 |=>
    freq_out == (n == 16'h6)) else $error("sixth rise");
  chk_period_start: assert property (
    $rose(freq_in) && n >= start_count &&
    (n - start_count) % ratio == 16'h0 |=> freq_out)
    else $error("period start low");
endmodule
bind pefd_divider pefd_chk u_chk (
  .clock(clock),
  .rst_n(rst_n),
  .freq_in(freq_in),
  .freq_out(freq_out),
  .ratio(ratio),
  .pulse_len(pulse_len),
  .start_count(start_count)
);

// file: sim/pefd_src.sv
// Edge source model
`timescale 1ns/100ps
module pefd_src (
  input wire logic clock,
  input wire logic rst_n,
  output logic freq_in = 1'b0
);
  // Low in reset: no stale level reads as a rise
  always @(negedge clock) freq_in <= rst_n & ~freq_in;
endmodule

// file: sim/tb_programmable_edge_frequency_divider.sv
// Divider bench
`timescale 1ns/100ps
module tb_programmable_edge_frequency_divider;
  logic clock = 1'b0, rst_n = 1'b0, freq_in, freq_out;
  logic [15:0] ratio = 16'h2, pulse_len = 16'h1, start_count = 16'h0;
  int mismatches = 0, comparisons = 0;
  initial forever #2 clock = ~clock;
  pefd_src src (
    .clock(clock),
    .rst_n(rst_n),
    .freq_in(freq_in)
  );
  pefd_divider dut (
    .clock(clock),
    .rst_n(rst_n),
    .freq_in(freq_in),
    .ratio(ratio),
    .pulse_len(pulse_len),
    .start_count(start_count),
    .freq_out(freq_out)
  );
  task check(input logic got, exp);
    comparisons++;
    if (got !== exp) $display("[FAIL] freq_out exp %b got %b", exp, got);
    mismatches += (got !== exp);
  endtask
  task print_verdict;
    if (!mismatches && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task go(input logic [15:0] r, l, s);
    @(negedge clock);
    {rst_n, ratio, pulse_len, start_count} <= {1'b0, r, l, s};
    repeat (20) @(negedge clock);
    rst_n <= 1'b1;
    for (int k = 1; k <= s + 2 * r + 2; k++) begin
      repeat (2) @(negedge clock);
      check(freq_out, k > s && (k - s - 1) % r < l);
    end
  endtask
  task t_def; go(16'h2, 16'h1, 16'h0); endtask
  task t_late; go(16'h4, 16'h2, 16'h5); endtask
  task t_wide; go(16'ha, 16'h3, 16'h0); endtask
  task t_one; go(16'h1, 16'h1, 16'h0); endtask
  initial begin
    t_def;
    t_late;
    t_wide;
    t_one;
    print_verdict;
  end
  initial begin
    #3000 mismatches++;
    print_verdict;
  end
endmodule
